// ===== rsp_pkg.sv
// shared constants and types of the rail setpoint and error sampling block
package rsp_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_ONOFF     = 8'h00;
	localparam logic [7:0] ADDR_OPERATION = 8'h04;
	localparam logic [7:0] ADDR_VID_CFG   = 8'h08;
	localparam logic [7:0] ADDR_VID_CODE  = 8'h0C;
	localparam logic [7:0] ADDR_VOUT_CMD  = 8'h10;
	localparam logic [7:0] ADDR_CAL_OFS   = 8'h14;
	localparam logic [7:0] ADDR_SCALE     = 8'h18;
	localparam logic [7:0] ADDR_VOUT_MAX  = 8'h1C;
	localparam logic [7:0] ADDR_MRG_HIGH  = 8'h20;
	localparam logic [7:0] ADDR_MRG_LOW   = 8'h24;
	localparam logic [7:0] ADDR_SAMPLE    = 8'h28;
	localparam logic [7:0] ADDR_GAINS     = 8'h2C;
	localparam logic [7:0] ADDR_STATUS    = 8'h30;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ONOFF_SRC_LSB   = 0;
	localparam int ONOFF_POL_BIT   = 3;
	localparam int OP_SUPPRESS_BIT = 3;
	localparam int OP_MARGIN_LSB   = 4;
	localparam int OP_ON_BIT       = 7;
	localparam int VID_MODE_BIT    = 0;
	localparam int VID_START_LSB   = 8;
	localparam int VID_LOW_LSB     = 16;
	localparam int VID_HIGH_LSB    = 24;
	localparam int VID_DAC_SHIFT   = 2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] ONOFF_RST     = 32'h0000000B;
	localparam logic [31:0] OPERATION_RST = 32'h00000000;
	localparam logic [31:0] VID_CFG_RST   = 32'hFF000000;
	localparam logic [15:0] SCALE_RST     = 16'h8000;
	localparam logic [15:0] VOUT_MAX_RST  = 16'hFFFF;
	localparam logic [5:0]  GAINS_RST     = 6'h2A;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_OFF  = 3'b000,
		SRC_AUTO = 3'b001,
		SRC_PIN  = 3'b010,
		SRC_OP   = 3'b011,
		SRC_AND  = 3'b100
	} rsp_onoff_src_t;

	typedef enum logic [1:0] {
		MRG_NOM  = 2'b00,
		MRG_LOW  = 2'b01,
		MRG_HIGH = 2'b10
	} rsp_margin_t;

	typedef enum logic [1:0] {
		ST_HOLD  = 2'b00,
		ST_START = 2'b01,
		ST_RUN   = 2'b10
	} rsp_state_t;

	// ------------------------------------------------------------
	// error adc and timing
	// ------------------------------------------------------------
	localparam logic signed [15:0] ADC_MAX   = 16'sh001F;
	localparam logic signed [15:0] ADC_MIN   = -16'sh0020;
	localparam logic [1:0]         GAIN_TOP  = 2'h3;
	localparam logic [9:0]         DAC_FULL  = 10'h3FF;
	localparam logic signed [10:0] OFS_LIMIT = 11'sh3FF;

	localparam int CLK_PERIOD_NS       = 50;
	localparam int STARTUP_TIME_NS     = 100000;
	localparam int STARTUP_CYCLES      = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DAC_LSB_MV          = 2;
	localparam int DAC_LSB_UV          = 2000;
	localparam int SLEW_RATE_UV_PER_US = 156;
	localparam int SLEW_STEP_NS        = DAC_LSB_UV * 1000 / SLEW_RATE_UV_PER_US;
	localparam int SLEW_STEP_CYCLES    = SLEW_STEP_NS / CLK_PERIOD_NS;

endpackage

// ===== rsp_rail_ctrl.sv
// rail control: reset entry, on/off source, setpoint, error sampling
// ------------------------------------------------------------
// Overview of operation
// - supply above power-on threshold starts startup sequence, then normal operation
// - external reset pin low holds the device in reset
// - on/off source: off, auto, pin only, operation only, pin AND operation
// - on/off config also sets control pin polarity
// - vid_mode_config selects steady programmed setpoint or dynamic vid codes
// - nominal setpoint from command, calibration offset, loop scale and maximum
// - operation selects nominal, margin high or margin low setpoint
// - operation option suppresses voltage faults while margined
// - sense sampled at programmable time within switching period
// - sense subtracted from 10-bit dac reference, amplified, then converted
// - gain codes 0..3 give 1x,2x,4x,8x at 8,4,2,1 mV per lsb
// - gain stored per coefficient bank: ramp, regulation, light load
// - error beyond range reads saturated -32 or 31
// - while saturated dac slews toward sense at 0.156 V/ms
// - vid_mode_config holds mode, upper and lower limits, power-up code
// - bank 0 ramp or tracking, bank 1 regulation, bank 2 light load
// ------------------------------------------------------------
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module rsp_rail_ctrl import rsp_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        logicSupplyOk,
	input  wire logic        externalResetPinN,
	input  wire logic        controlPin,
	input  wire logic        rampActive,
	input  wire logic        lightLoad,
	input  wire logic        periodStart,
	input  wire logic [11:0] sensePosInput,
	input  wire logic [11:0] senseNegInput,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             deviceReady,
	output logic             railOn,
	output logic [9:0]       dacCode,
	output logic [5:0]       errorAdcCode,
	output logic             sampleStrobe,
	output logic [1:0]       activeBank,
	output logic [1:0]       frontendGainCode,
	output logic             faultSuppress
);

	rsp_state_t         state_q;
	logic [11:0]        startCnt_q;
	logic [31:0]        onoff_q;
	logic [31:0]        operation_q;
	logic [31:0]        vidCfg_q;
	logic [7:0]         vidCode_q;
	logic [15:0]        voutCmd_q;
	logic [15:0]        calOfs_q;
	logic [15:0]        scale_q;
	logic [15:0]        voutMax_q;
	logic [15:0]        mrgHigh_q;
	logic [15:0]        mrgLow_q;
	logic [15:0]        sampleTime_q;
	logic [5:0]         gains_q;
	logic [15:0]        periodCnt_q;
	logic               armed_q;
	logic               satHigh_q;
	logic               satLow_q;
	logic [31:0]        prdata_q;
	logic               pready_q;
	logic               pslverr_q;
	logic               railOn_q;
	logic [9:0]         dacCode_q;
	logic [5:0]         errorAdcCode_q;
	logic               sampleStrobe_q;
	logic [1:0]         activeBank_q;
	logic [1:0]         gainSel_q;
	logic               faultSuppress_q;
	logic               ready_q;
	logic               pinOn;
	logic               opOn;
	logic               wrEn;
	logic               rdPhase;
	logic               mapped;
	logic [31:0]        rdValue;
	logic [9:0]         setpoint;
	logic [9:0]         dacNext;
	logic signed [15:0] errCode;
	logic               running;
	rsp_margin_t        margin;
	rsp_onoff_src_t     src;

	rsp_slew_if slewBus ();

	rsp_slew_unit rsp_slew_unit_i (
		.clk (clk),
		.rst (rst),
		.sl  (slewBus)
	);

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign deviceReady      = ready_q;
	assign railOn           = railOn_q;
	assign dacCode          = dacCode_q;
	assign errorAdcCode     = errorAdcCode_q;
	assign sampleStrobe     = sampleStrobe_q;
	assign activeBank       = activeBank_q;
	assign frontendGainCode = gainSel_q;
	assign faultSuppress    = faultSuppress_q;
	assign running          = (state_q == ST_RUN);

	// ------------------------------------------------------------
	// setting in mV to dac code: offset, clamp to max, scale, saturate
	// ------------------------------------------------------------
	function automatic logic [9:0] settingToDac(input logic [15:0] raw, input logic [15:0] ofs,
						    input logic [15:0] vmax, input logic [15:0] scl);
		logic signed [17:0] sum;
		logic [16:0]        lim;
		logic [32:0]        prod;
		logic [16:0]        dacWide;
		sum = $signed({2'b00, raw}) + $signed({{2{ofs[15]}}, ofs});
		if (sum < 18'sh00000) begin
			lim = 17'h00000;
		end else if (sum > $signed({2'b00, vmax})) begin
			lim = {1'b0, vmax};
		end else begin
			lim = sum[16:0];
		end
		prod    = {16'h0000, lim} * {17'h00000, scl};
		dacWide = 17'(prod[32:16] / 17'(DAC_LSB_MV));
		// saturate rather than wrap if the host breaks the dac limit
		if (dacWide > {7'h00, DAC_FULL}) begin
			return DAC_FULL;
		end
		return dacWide[9:0];
	endfunction

	// ------------------------------------------------------------
	// reset entry and startup sequence
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q    <= ST_HOLD;
			startCnt_q <= 12'h000;
			ready_q    <= 1'b0;
		end else if (!logicSupplyOk || !externalResetPinN) begin
			state_q    <= ST_HOLD;
			startCnt_q <= 12'h000;
			ready_q    <= 1'b0;
		end else begin
			case (state_q)
				ST_HOLD: begin
					state_q    <= ST_START;
					startCnt_q <= 12'h000;
				end
				ST_START: begin
					if (startCnt_q == 12'(STARTUP_CYCLES - 1)) begin
						state_q <= ST_RUN;
						ready_q <= 1'b1;
					end else begin
						startCnt_q <= startCnt_q + 12'h001;
					end
				end
				ST_RUN: begin
					state_q <= ST_RUN;
				end
				default: begin
					state_q <= ST_HOLD;
					ready_q <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// apb slave: one wait state so read data comes from a flop
	// ------------------------------------------------------------
	assign rdPhase = psel && penable && !pready_q;
	assign wrEn    = psel && penable && pready_q && pwrite && mapped;

	always_comb begin
		mapped  = 1'b1;
		rdValue = 32'h00000000;
		case (paddr)
			ADDR_ONOFF:     rdValue = onoff_q;
			ADDR_OPERATION: rdValue = operation_q;
			ADDR_VID_CFG:   rdValue = vidCfg_q;
			ADDR_VID_CODE:  rdValue = {24'h000000, vidCode_q};
			ADDR_VOUT_CMD:  rdValue = {16'h0000, voutCmd_q};
			ADDR_CAL_OFS:   rdValue = {16'h0000, calOfs_q};
			ADDR_SCALE:     rdValue = {16'h0000, scale_q};
			ADDR_VOUT_MAX:  rdValue = {16'h0000, voutMax_q};
			ADDR_MRG_HIGH:  rdValue = {16'h0000, mrgHigh_q};
			ADDR_MRG_LOW:   rdValue = {16'h0000, mrgLow_q};
			ADDR_SAMPLE:    rdValue = {16'h0000, sampleTime_q};
			ADDR_GAINS:     rdValue = {26'h0000000, gains_q};
			ADDR_STATUS:    rdValue = {6'h00, dacCode_q, errorAdcCode_q, activeBank_q, gainSel_q,
						   satLow_q, satHigh_q, faultSuppress_q, railOn_q, state_q};
			default:        mapped = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end else begin
			pready_q  <= rdPhase;
			pslverr_q <= rdPhase && !mapped;
			if (rdPhase) begin
				prdata_q <= (pwrite || !mapped) ? 32'h00000000 : rdValue;
			end
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			onoff_q      <= ONOFF_RST;
			operation_q  <= OPERATION_RST;
			vidCfg_q     <= VID_CFG_RST;
			voutCmd_q    <= 16'h0000;
			calOfs_q     <= 16'h0000;
			scale_q      <= SCALE_RST;
			voutMax_q    <= VOUT_MAX_RST;
			mrgHigh_q    <= 16'h0000;
			mrgLow_q     <= 16'h0000;
			sampleTime_q <= 16'h0000;
			gains_q      <= GAINS_RST;
		end else if (wrEn) begin
			case (paddr)
				ADDR_ONOFF:     onoff_q      <= {28'h0000000, pwdata[3:0]};
				ADDR_OPERATION: operation_q  <= {24'h000000, pwdata[7:0]};
				ADDR_VID_CFG:   vidCfg_q     <= {pwdata[31:8], 7'h00, pwdata[0]};
				ADDR_VOUT_CMD:  voutCmd_q    <= pwdata[15:0];
				ADDR_CAL_OFS:   calOfs_q     <= pwdata[15:0];
				ADDR_SCALE:     scale_q      <= pwdata[15:0];
				ADDR_VOUT_MAX:  voutMax_q    <= pwdata[15:0];
				ADDR_MRG_HIGH:  mrgHigh_q    <= pwdata[15:0];
				ADDR_MRG_LOW:   mrgLow_q     <= pwdata[15:0];
				ADDR_SAMPLE:    sampleTime_q <= pwdata[15:0];
				ADDR_GAINS:     gains_q      <= pwdata[5:0];
				default:        gains_q      <= gains_q;
			endcase
		end
	end

	// power-up vid code loaded at the end of startup; later bus writes steer it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vidCode_q <= 8'h00;
		end else if (state_q == ST_START && startCnt_q == 12'(STARTUP_CYCLES - 1)) begin
			vidCode_q <= vidCfg_q[VID_START_LSB +: 8];
		end else if (wrEn && paddr == ADDR_VID_CODE) begin
			vidCode_q <= pwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// setpoint selection and dac drive
	// ------------------------------------------------------------
	assign margin = rsp_margin_t'(operation_q[OP_MARGIN_LSB +: 2]);

	always_comb begin
		logic [7:0] code;
		code = vidCode_q;
		if (vidCfg_q[VID_MODE_BIT]) begin
			// limits bound the vid code before it reaches the dac
			if (code > vidCfg_q[VID_HIGH_LSB +: 8]) begin
				code = vidCfg_q[VID_HIGH_LSB +: 8];
			end
			if (code < vidCfg_q[VID_LOW_LSB +: 8]) begin
				code = vidCfg_q[VID_LOW_LSB +: 8];
			end
			setpoint = {code, 2'b00} >> (VID_DAC_SHIFT - 2);
		end else begin
			case (margin)
				MRG_HIGH: setpoint = settingToDac(mrgHigh_q, calOfs_q, voutMax_q, scale_q);
				MRG_LOW:  setpoint = settingToDac(mrgLow_q, calOfs_q, voutMax_q, scale_q);
				default:  setpoint = settingToDac(voutCmd_q, calOfs_q, voutMax_q, scale_q);
			endcase
		end
	end

	always_comb begin
		logic signed [11:0] sum;
		sum = $signed({2'b00, setpoint}) + $signed({slewBus.offset[10], slewBus.offset});
		if (sum < 12'sh000) begin
			dacNext = 10'h000;
		end else if (sum > $signed({2'b00, DAC_FULL})) begin
			dacNext = DAC_FULL;
		end else begin
			dacNext = sum[9:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dacCode_q <= 10'h000;
		end else begin
			dacCode_q <= running ? dacNext : 10'h000;
		end
	end

	// ------------------------------------------------------------
	// sample timing, error conversion and saturation
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			periodCnt_q    <= 16'h0000;
			armed_q        <= 1'b0;
			sampleStrobe_q <= 1'b0;
		end else if (periodStart) begin
			periodCnt_q    <= 16'h0000;
			armed_q        <= 1'b1;
			sampleStrobe_q <= 1'b0;
		end else begin
			if (periodCnt_q != 16'hFFFF) begin
				periodCnt_q <= periodCnt_q + 16'h0001;
			end
			sampleStrobe_q <= running && armed_q && periodCnt_q == sampleTime_q;
			if (periodCnt_q == sampleTime_q) begin
				armed_q <= 1'b0;
			end
		end
	end

	always_comb begin
		logic signed [15:0] diffMv;
		diffMv  = $signed({4'h0, dacCode_q, 2'b00}) / 16'(DAC_LSB_MV * 2) * 16'(DAC_LSB_MV)
			  - ($signed({4'h0, sensePosInput}) - $signed({4'h0, senseNegInput}));
		errCode = diffMv >>> (GAIN_TOP - gainSel_q);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			errorAdcCode_q <= 6'h00;
			satHigh_q      <= 1'b0;
			satLow_q       <= 1'b0;
		end else if (!running) begin
			errorAdcCode_q <= 6'h00;
			satHigh_q      <= 1'b0;
			satLow_q       <= 1'b0;
		end else if (sampleStrobe_q) begin
			satHigh_q <= errCode > ADC_MAX;
			satLow_q  <= errCode < ADC_MIN;
			if (errCode > ADC_MAX) begin
				errorAdcCode_q <= ADC_MAX[5:0];
			end else if (errCode < ADC_MIN) begin
				errorAdcCode_q <= ADC_MIN[5:0];
			end else begin
				errorAdcCode_q <= errCode[5:0];
			end
		end
	end

	assign slewBus.satHigh = satHigh_q;
	assign slewBus.satLow  = satLow_q;
	assign slewBus.clear   = !running;

	// ------------------------------------------------------------
	// rail enable, bank and gain, fault suppression
	// ------------------------------------------------------------
	assign src   = rsp_onoff_src_t'(onoff_q[ONOFF_SRC_LSB +: 3]);
	assign pinOn = (controlPin == onoff_q[ONOFF_POL_BIT]);
	assign opOn  = operation_q[OP_ON_BIT];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			railOn_q        <= 1'b0;
			activeBank_q    <= 2'h1;
			gainSel_q       <= GAINS_RST[3:2];
			faultSuppress_q <= 1'b0;
		end else begin
			case (src)
				SRC_AUTO: railOn_q <= running;
				SRC_PIN:  railOn_q <= running && pinOn;
				SRC_OP:   railOn_q <= running && opOn;
				SRC_AND:  railOn_q <= running && pinOn && opOn;
				default:  railOn_q <= 1'b0;
			endcase
			if (rampActive) begin
				activeBank_q <= 2'h0;
				gainSel_q    <= gains_q[1:0];
			end else if (lightLoad) begin
				activeBank_q <= 2'h2;
				gainSel_q    <= gains_q[5:4];
			end else begin
				activeBank_q <= 2'h1;
				gainSel_q    <= gains_q[3:2];
			end
			faultSuppress_q <= operation_q[OP_SUPPRESS_BIT] && !vidCfg_q[VID_MODE_BIT]
					   && (margin == MRG_HIGH || margin == MRG_LOW);
		end
	end

endmodule

// ===== rsp_rail_ctrl_props.sv
// checker for the rail control block ports
`timescale 1ns/1ns
module rsp_rail_ctrl_props import rsp_pkg::*; (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       logicSupplyOk,
	input wire logic       externalResetPinN,
	input wire logic       rampActive,
	input wire logic       lightLoad,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       deviceReady,
	input wire logic       railOn,
	input wire logic [9:0] dacCode,
	input wire logic [5:0] errorAdcCode,
	input wire logic       sampleStrobe,
	input wire logic [1:0] activeBank
);
	// ----
	// properties
	// ----
	logic [11:0] waitCnt_q;
	// saturates so a long wait cannot wrap round into a short count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waitCnt_q <= 12'h000;
		end else if (deviceReady || !logicSupplyOk || !externalResetPinN) begin
			waitCnt_q <= 12'h000;
		end else if (waitCnt_q != 12'hFFF) begin
			waitCnt_q <= waitCnt_q + 12'h001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_setup; psel && !penable; endsequence
	sequence s_wait; psel && penable && !pready; endsequence
	property p_pready; s_setup ##1 s_wait |=> pready; endproperty
	a_pready: assert property (p_pready) else $error("bus answer late");
	// the strobe is launched by the edge that may also drop out of run
	property p_strobe; sampleStrobe |-> $past(deviceReady) ##1 !sampleStrobe; endproperty
	a_strobe: assert property (p_strobe) else $error("sample strobe wrong");
	property p_adcHold; deviceReady && $past(deviceReady) && !$past(sampleStrobe) |-> $stable(errorAdcCode); endproperty
	a_adcHold: assert property (p_adcHold) else $error("adc code moved without sample");
	property p_pinHold; !externalResetPinN |-> ##2 (!deviceReady && !railOn); endproperty
	a_pinHold: assert property (p_pinHold) else $error("reset pin not obeyed");
	property p_supply; !logicSupplyOk |-> ##2 !deviceReady; endproperty
	a_supply: assert property (p_supply) else $error("low supply not obeyed");
	property p_startup; $rose(deviceReady) |-> waitCnt_q >= STARTUP_CYCLES - 1; endproperty
	a_startup: assert property (p_startup) else $error("startup too short");
	property p_dacIdle; !deviceReady ##1 !deviceReady |-> dacCode == 10'h000 && !railOn; endproperty
	a_dacIdle: assert property (p_dacIdle) else $error("dac or rail live in reset");
	property p_bankRamp; rampActive |=> activeBank == 2'h0; endproperty
	a_bankRamp: assert property (p_bankRamp) else $error("ramp bank wrong");
	property p_bankLight; lightLoad && !rampActive |=> activeBank == 2'h2; endproperty
	a_bankLight: assert property (p_bankLight) else $error("light bank wrong");
endmodule
bind rsp_rail_ctrl rsp_rail_ctrl_props rsp_rail_ctrl_props_i (.clk, .rst, .logicSupplyOk, .externalResetPinN,
	.rampActive, .lightLoad, .psel, .penable, .pready, .deviceReady, .railOn, .dacCode, .errorAdcCode,
	.sampleStrobe, .activeBank);

// ===== rsp_sense_model.sv
// sense network and switching period source
`timescale 1ns/1ns
module rsp_sense_model (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [11:0] level,
	output logic            periodStart,
	output logic [11:0]     sensePos,
	output logic [11:0]     senseNeg
);
	// ----
	// period and sense levels
	// ----
	logic [5:0] cnt_q;
	// a 40 cycle period leaves room for any sample time the bench sets
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q       <= 6'h00;
			periodStart <= 1'b0;
		end else begin
			cnt_q       <= (cnt_q == 6'h27) ? 6'h00 : cnt_q + 6'h01;
			periodStart <= (cnt_q == 6'h00);
		end
	end
	// common mode offset shows that only the difference counts
	assign senseNeg = 12'h064;
	assign sensePos = level + 12'h064;
endmodule

// ===== rsp_slew_if.sv
// saturation flags and slew offset passed between control and slew unit
`timescale 1ns/1ns
interface rsp_slew_if;
	logic               satHigh;
	logic               satLow;
	logic               clear;
	logic signed [10:0] offset;

	modport ctrl (output satHigh, output satLow, output clear, input offset);
	modport slew (input satHigh, input satLow, input clear, output offset);
endinterface

// ===== rsp_slew_unit.sv
// setpoint slew offset generator used while the error adc saturates
`timescale 1ns/1ns
module rsp_slew_unit import rsp_pkg::*; (
	input  wire logic clk,
	input  wire logic rst,
	rsp_slew_if.slew  sl
);

	logic [11:0]        stepCnt_q;
	logic signed [10:0] offset_q;

	assign sl.offset = offset_q;

	// ------------------------------------------------------------
	// one dac lsb per step period keeps the rate fixed at any gain
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stepCnt_q <= 12'h000;
			offset_q  <= 11'sh000;
		end else if (sl.clear) begin
			stepCnt_q <= 12'h000;
			offset_q  <= 11'sh000;
		end else if (sl.satHigh || sl.satLow) begin
			if (stepCnt_q == 12'(SLEW_STEP_CYCLES - 1)) begin
				stepCnt_q <= 12'h000;
				if (sl.satHigh && offset_q != -OFS_LIMIT) begin
					offset_q <= offset_q - 11'sh001;
				end else if (sl.satLow && offset_q != OFS_LIMIT) begin
					offset_q <= offset_q + 11'sh001;
				end
			end else begin
				stepCnt_q <= stepCnt_q + 12'h001;
			end
		end else begin
			stepCnt_q <= 12'h000;
		end
	end

endmodule

// ===== test_rsp_rail_ctrl.sv
// self-checking bench of the rail control block
`timescale 1ns/1ns
module test_rsp_rail_ctrl import rsp_pkg::*;;
	// ----
	// signals and tasks
	// ----
	logic        clk, rst, logicSupplyOk, externalResetPinN, controlPin, rampActive, lightLoad, perr;
	logic        psel, penable, pwrite, pready, pslverr, deviceReady, railOn, sampleStrobe, faultSuppress, periodStart;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [9:0]  dacCode;
	logic [5:0]  errorAdcCode;
	logic [1:0]  activeBank, frontendGainCode;
	logic [11:0] sensePosInput, senseNegInput, level;
	int          miscompares = 0, n_compared = 0;
	logic [15:0] tbl [10] = '{16'h0802, 16'h1001, 16'hA003, 16'h2001, 16'h2002, 16'h3801, 16'h3002, 16'hC803,
		16'hC800, 16'hC002};
	rsp_rail_ctrl rsp_rail_ctrl_i (.clk, .rst, .logicSupplyOk, .externalResetPinN, .controlPin, .rampActive,
		.lightLoad, .periodStart, .sensePosInput, .senseNegInput, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .deviceReady, .railOn, .dacCode, .errorAdcCode, .sampleStrobe, .activeBank,
		.frontendGainCode, .faultSuppress);
	rsp_sense_model rsp_sense_model_i (.clk, .rst, .level, .periodStart, .sensePos(sensePosInput),
		.senseNeg(senseNegInput));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task wrap_up;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// the slave is said to add one wait state, but only pready is trusted
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task wd(input logic [7:0] a, input logic [31:0] d, input logic [9:0] e);
		wr(a, d);
		repeat (4) @(posedge clk);
		chk("dac", dacCode, e);
	endtask
	task waitReady;
		wait (deviceReady === 1'b1);
		repeat (4) @(posedge clk);
	endtask
	task adcWait;
		repeat (2) @(posedge sampleStrobe);
		repeat (2) @(posedge clk);
	endtask
	task bk(input logic r, input logic l, input logic [1:0] b, input logic [1:0] g);
		rampActive <= r;
		lightLoad  <= l;
		repeat (3) @(posedge clk);
		chk("bank", activeBank, b);
		chk("gain", frontendGainCode, g);
	endtask
	// ----
	// scenarios
	// ----
	task t_regs;
		apb(1'b0, ADDR_ONOFF, 32'h0);
		chk("onoff", rdat, 32'h0000000B);
		wr(ADDR_VOUT_CMD, 32'h3E8);
		apb(1'b0, ADDR_VOUT_CMD, 32'h0);
		chk("vout", rdat, 32'h000003E8);
		apb(1'b0, 8'h3C, 32'h0);
		chk("slverr", perr, 1'b1);
	endtask
	task t_onoff;
		for (int i = 0; i < 10; i++) begin
			wr(ADDR_ONOFF, {28'h0, tbl[i][15:12]});
			wr(ADDR_OPERATION, {24'h0, tbl[i][11:4]});
			controlPin <= tbl[i][1];
			repeat (4) @(posedge clk);
			chk("railOn", railOn, tbl[i][0]);
		end
		wr(ADDR_ONOFF, 32'h1);
	endtask
	task t_setpoint;
		wd(ADDR_SCALE, 32'h8000, 10'h0FA);
		wd(ADDR_VOUT_MAX, 32'h320, 10'h0C8);
		wd(ADDR_VOUT_MAX, 32'hFFFF, 10'h0FA);
		wd(ADDR_CAL_OFS, 32'hFFFFFF38, 10'h0C8);
		wd(ADDR_CAL_OFS, 32'h0, 10'h0FA);
		wr(ADDR_MRG_HIGH, 32'h4B0);
		wr(ADDR_MRG_LOW, 32'h320);
		wd(ADDR_OPERATION, 32'hA8, 10'h12C);
		chk("suppress", faultSuppress, 1'b1);
		wd(ADDR_OPERATION, 32'h90, 10'h0C8);
		chk("suppress", faultSuppress, 1'b0);
		wd(ADDR_OPERATION, 32'h80, 10'h0FA);
		wr(ADDR_VID_CODE, 32'h40);
		wd(ADDR_VID_CFG, 32'h80104001, 10'h100);
		wd(ADDR_VID_CODE, 32'hF0, 10'h200);
		wd(ADDR_VID_CODE, 32'h04, 10'h040);
		wd(ADDR_VID_CFG, 32'hFF000000, 10'h0FA);
	endtask
	task t_adc;
		wr(ADDR_SAMPLE, 32'h5);
		level <= 12'h1DC;
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_GAINS, 32'h22 + 32'(g * 4));
			adcWait;
			chk("adc", errorAdcCode, 6'(24 >> (3 - g)));
			chk("gain", frontendGainCode, g[1:0]);
		end
		level <= 12'h190;
		adcWait;
		chk("sathigh", errorAdcCode, 6'h1F);
		repeat (700) @(posedge clk);
		chk("slewdown", dacCode < 10'h0FA, 1'b1);
		level <= 12'h1F4;
	endtask
	task t_bank;
		wr(ADDR_GAINS, 32'h1C);
		bk(1'b1, 1'b1, 2'h0, 2'h0);
		bk(1'b0, 1'b1, 2'h2, 2'h1);
		bk(1'b0, 1'b0, 2'h1, 2'h3);
		wr(ADDR_GAINS, 32'h2A);
	endtask
	task t_reset;
		externalResetPinN <= 1'b0;
		repeat (5) @(posedge clk);
		chk("ready", deviceReady, 1'b0);
		chk("rail", railOn, 1'b0);
		externalResetPinN <= 1'b1;
		repeat (100) @(posedge clk);
		chk("ready", deviceReady, 1'b0);
		waitReady;
		chk("dac", dacCode, 10'h0FA);
		logicSupplyOk <= 1'b0;
		repeat (5) @(posedge clk);
		chk("ready", deviceReady, 1'b0);
		logicSupplyOk <= 1'b1;
		waitReady;
		chk("rail", railOn, 1'b1);
		level <= 12'h244;
		adcWait;
		chk("satlow", errorAdcCode, 6'h20);
		repeat (700) @(posedge clk);
		chk("slewup", dacCode > 10'h0FA, 1'b1);
	endtask
	// ----
	// clock, watchdog and main sequence
	// ----
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// three startups and two slews fit well inside this span
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		wrap_up;
	end
	initial begin
		{rst, logicSupplyOk, externalResetPinN, controlPin, rampActive, lightLoad, psel, penable, pwrite} = 9'h1C0;
		{paddr, pwdata} = 40'h0;
		level = 12'h1F4;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		waitReady;
		t_regs;
		t_onoff;
		t_setpoint;
		t_adc;
		t_bank;
		t_reset;
		wrap_up;
	end
endmodule
